//--- rtl/blcfg_pkg.sv
package blcfg_pkg;

  // ************************************************************
  // Bus addressing
  // ************************************************************
  localparam logic [6:0] SLAVE_ADDR      = 7'h2C;
  localparam logic [7:0] OFS_SLEW        = 8'hA4;
  localparam logic [7:0] OFS_OCEN        = 8'hA5;
  localparam logic [7:0] OFS_CONTROL     = 8'hFF;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int         SLEW_MSB        = 1;
  localparam int         OCEN_BIT        = 0;
  localparam int         SAVE_BIT        = 7;
  localparam int         RDSEL_BIT       = 0;
  localparam logic [1:0] SLEW_RESET      = 2'h0;
  localparam logic       OCEN_RESET      = 1'b0;
  localparam logic       SAVE_RESET      = 1'b0;
  localparam logic       RDSEL_RESET     = 1'b0;
  localparam logic [7:0] NV_RESET        = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int         CLK_PERIOD_NS   = 5;
  localparam int         SAVE_TIME_MS    = 50;
  localparam int         SAVE_CYCLES     = (SAVE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int         NV_ENTRIES      = 2;
  localparam int         SAVE_CNT_W      = 24;

endpackage : blcfg_pkg

//--- rtl/blcfg_nv_store.sv
`timescale 1ns/100ps
`default_nettype none

module blcfg_nv_store #(
  parameter int unsigned SAVE_CYCLES = blcfg_pkg::SAVE_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       save_start_i,
  input  wire logic [7:0] slew_word_i,
  input  wire logic [7:0] ocen_word_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      nv_slew_o,
  output logic [7:0]      nv_ocen_o
);

  // ************************************************************
  // Save engine
  // ************************************************************
  // The save time is shared evenly among the entries, one array write per slot.
  localparam int unsigned SLOT = (SAVE_CYCLES / blcfg_pkg::NV_ENTRIES > 0) ?
                                 SAVE_CYCLES / blcfg_pkg::NV_ENTRIES : 1;

  logic [7:0]                      nv_mem [blcfg_pkg::NV_ENTRIES];
  logic [7:0]                      snap   [blcfg_pkg::NV_ENTRIES];
  logic [blcfg_pkg::SAVE_CNT_W-1:0] cnt;
  logic                            idx;
  logic                            slot_end;

  assign slot_end  = (cnt == blcfg_pkg::SAVE_CNT_W'(SLOT - 1));
  assign nv_slew_o = nv_mem[0];
  assign nv_ocen_o = nv_mem[1];

  always_ff @(posedge ref_clk_i) begin
    done_o <= 1'b0;
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      cnt    <= '0;
      idx    <= 1'b0;
      for (int i = 0; i < blcfg_pkg::NV_ENTRIES; i++) begin
        nv_mem[i] <= blcfg_pkg::NV_RESET;
        snap[i]   <= blcfg_pkg::NV_RESET;
      end
    end else if (!busy_o) begin
      if (save_start_i) begin
        busy_o  <= 1'b1;
        cnt     <= '0;
        idx     <= 1'b0;
        snap[0] <= slew_word_i;
        snap[1] <= ocen_word_i;
      end
    end else if (slot_end) begin
      nv_mem[idx] <= snap[idx];
      cnt         <= '0;
      idx         <= ~idx;
      if (idx) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule : blcfg_nv_store

`default_nettype wire

//--- rtl/blcfg_regs.sv
`timescale 1ns/100ps
`default_nettype none

module blcfg_regs #(
  parameter int unsigned SAVE_CYCLES = blcfg_pkg::SAVE_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic [1:0]      slew_rate_sel_o,
  output logic            overcurrent_shutdown_en_o,
  output logic            nv_read_select_o,
  output logic            nv_save_trigger_o
);

  // ************************************************************
  // Pin synchronisers and bus conditions
  // ************************************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  wire scl_s     = scl_sync[1];
  wire sda_s     = sda_sync[1];
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // ************************************************************
  // Protocol state
  // ************************************************************
  typedef enum logic [2:0] {
    BLCFG_IDLE, BLCFG_ADDR, BLCFG_ACK, BLCFG_RX, BLCFG_TX, BLCFG_TXACK
  } blcfg_state_t;

  blcfg_state_t state;
  logic [7:0]   shift;
  logic [3:0]   bit_cnt;
  logic         rd_mode;
  logic         ptr_valid;
  logic         addr_ack;
  logic [7:0]   reg_ptr;
  logic [1:0]   slew;
  logic         ocen;
  logic         save_trig;
  logic         rd_sel;
  logic         nv_busy;
  logic         nv_done;
  logic [7:0]   nv_slew;
  logic [7:0]   nv_ocen;

  // ************************************************************
  // Register views and decode
  // ************************************************************
  wire [7:0] slew_word = {6'h00, slew};
  wire [7:0] ocen_word = {7'h00, ocen};
  wire [7:0] ctrl_word = {save_trig, 6'h00, rd_sel};

  wire hit_slew = (reg_ptr == blcfg_pkg::OFS_SLEW);
  wire hit_ocen = (reg_ptr == blcfg_pkg::OFS_OCEN);
  wire hit_ctrl = (reg_ptr == blcfg_pkg::OFS_CONTROL);

  wire [7:0] src_slew = rd_sel ? nv_slew : slew_word;
  wire [7:0] src_ocen = rd_sel ? nv_ocen : ocen_word;
  wire [7:0] rd_data  = hit_slew ? src_slew :
                        hit_ocen ? src_ocen :
                        hit_ctrl ? ctrl_word : 8'h00;

  wire byte_done  = scl_fall & (bit_cnt == 4'h8);
  wire addr_match = (shift[7:1] == blcfg_pkg::SLAVE_ADDR);
  wire data_byte  = (state == BLCFG_RX) & byte_done & ptr_valid;
  wire wr_slew    = data_byte & hit_slew;
  wire wr_ocen    = data_byte & hit_ocen;
  wire wr_ctrl    = data_byte & hit_ctrl;
  wire save_go    = stop_det & save_trig & ~nv_busy;

  // ************************************************************
  // Byte engine
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state     <= BLCFG_IDLE;
      shift     <= 8'h00;
      bit_cnt   <= 4'h0;
      rd_mode   <= 1'b0;
      ptr_valid <= 1'b0;
      addr_ack  <= 1'b0;
      reg_ptr   <= 8'h00;
    end else if (start_det) begin
      state   <= BLCFG_ADDR;
      bit_cnt <= 4'h0;
    end else if (stop_det) begin
      state <= BLCFG_IDLE;
    end else begin
      case (state)
        BLCFG_ADDR, BLCFG_RX: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            if (state == BLCFG_ADDR) begin
              state    <= addr_match ? BLCFG_ACK : BLCFG_IDLE;
              rd_mode  <= shift[0];
              addr_ack <= 1'b1;
              if (!shift[0]) begin
                ptr_valid <= 1'b0;
              end
            end else begin
              state    <= BLCFG_ACK;
              addr_ack <= 1'b0;
              if (!ptr_valid) begin
                reg_ptr   <= shift;
                ptr_valid <= 1'b1;
              end else begin
                reg_ptr <= reg_ptr + 8'h01;
              end
            end
          end
        end
        BLCFG_ACK: begin
          if (scl_fall) begin
            if (rd_mode) begin
              state <= BLCFG_TX;
              shift <= rd_data;
            end else begin
              state <= BLCFG_RX;
            end
          end
        end
        BLCFG_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              state   <= BLCFG_TXACK;
              bit_cnt <= 4'h0;
            end else begin
              shift   <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        BLCFG_TXACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state <= BLCFG_IDLE;
            end else begin
              reg_ptr <= reg_ptr + 8'h01;
            end
          end else if (scl_fall) begin
            state <= BLCFG_TX;
            shift <= rd_data;
          end
        end
        default: begin
          state <= BLCFG_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Working registers
  // ************************************************************
  // Writes land on the acknowledge, so the new setting drives the outputs next cycle.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      slew      <= blcfg_pkg::SLEW_RESET;
      ocen      <= blcfg_pkg::OCEN_RESET;
      save_trig <= blcfg_pkg::SAVE_RESET;
      rd_sel    <= blcfg_pkg::RDSEL_RESET;
    end else begin
      if (wr_slew) begin
        slew <= shift[blcfg_pkg::SLEW_MSB:0];
      end
      if (wr_ocen) begin
        ocen <= shift[blcfg_pkg::OCEN_BIT];
      end
      if (wr_ctrl) begin
        rd_sel    <= shift[blcfg_pkg::RDSEL_BIT];
        save_trig <= shift[blcfg_pkg::SAVE_BIT];
      end else if (nv_done) begin
        save_trig <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Nonvolatile store
  // ************************************************************
  blcfg_nv_store #(
    .SAVE_CYCLES (SAVE_CYCLES)
  ) u_nv_store (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .save_start_i (save_go),
    .slew_word_i  (slew_word),
    .ocen_word_i  (ocen_word),
    .busy_o       (nv_busy),
    .done_o       (nv_done),
    .nv_slew_o    (nv_slew),
    .nv_ocen_o    (nv_ocen)
  );

  // ************************************************************
  // Pin drivers
  // ************************************************************
  // Stretching only in the address acknowledge keeps the master parked before any
  // register is touched, so a transfer never observes a half-written store.
  wire stretch  = (state == BLCFG_ACK) & addr_ack & nv_busy;
  wire ack_low  = (state == BLCFG_ACK);
  wire tx_low   = (state == BLCFG_TX) & ~shift[7];

  assign scl_o                     = 1'b0;
  assign sda_o                     = 1'b0;
  assign scl_oe_o                  = stretch;
  assign sda_oe_o                  = ack_low | tx_low;
  assign slew_rate_sel_o           = slew;
  assign overcurrent_shutdown_en_o = ocen;
  assign nv_read_select_o          = rd_sel;
  assign nv_save_trigger_o         = save_trig;

endmodule : blcfg_regs

`default_nettype wire

//--- sim/blcfg_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module blcfg_regs_asserts #(
  parameter int unsigned SAVE_CYCLES = blcfg_pkg::SAVE_CYCLES
) (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       scl_o,
  input wire logic       scl_oe_o,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [1:0] slew_rate_sel_o,
  input wire logic       overcurrent_shutdown_en_o,
  input wire logic       nv_read_select_o,
  input wire logic       nv_save_trigger_o
);
  // ************************************************************
  // Cycle counters
  // ************************************************************
  int unsigned stretch_n;
  int unsigned idle_n;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A pending save may only outlast an idle bus by its fixed duration.
  always_ff @(posedge ref_clk_i) begin
    stretch_n <= (!rst_n_i || !scl_oe_o) ? 0 : stretch_n + 1;
    idle_n    <= (!rst_n_i || !nv_save_trigger_o || !scl_i || !sda_i) ? 0 : idle_n + 1;
  end
  a_pins_drive_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain value not low");
  a_sda_moves_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved while clock high");
  a_slew_on_ack: assert property ($changed(slew_rate_sel_o) |-> !scl_i ##[0:2] sda_oe_o)
    else $error("slew field changed outside acknowledge");
  a_ocen_on_ack: assert property ($changed(overcurrent_shutdown_en_o) |-> ##[0:2] sda_oe_o)
    else $error("shutdown enable changed outside acknowledge");
  a_rdsel_on_ack: assert property ($changed(nv_read_select_o) |-> ##[0:2] sda_oe_o)
    else $error("read select changed outside acknowledge");
  a_trig_set_ack: assert property ($rose(nv_save_trigger_o) |-> ##[0:2] sda_oe_o)
    else $error("save trigger set outside acknowledge");
  a_save_clears_bound: assert property (idle_n <= SAVE_CYCLES + 8)
    else $error("save trigger did not clear in time");
  a_stretch_in_save: assert property (scl_oe_o |-> nv_save_trigger_o || $past(nv_save_trigger_o))
    else $error("clock held low with no save running");
  a_stretch_bound: assert property (stretch_n <= SAVE_CYCLES + 8)
    else $error("clock held low too long");
endmodule : blcfg_regs_asserts
bind blcfg_regs blcfg_regs_asserts #(.SAVE_CYCLES(SAVE_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .slew_rate_sel_o(slew_rate_sel_o),
  .overcurrent_shutdown_en_o(overcurrent_shutdown_en_o), .nv_read_select_o(nv_read_select_o),
  .nv_save_trigger_o(nv_save_trigger_o));
`default_nettype wire

//--- sim/blcfg_i2c_master.sv
`timescale 1ns/100ps
`default_nettype none
module blcfg_i2c_master #(
  parameter int H = 20
) (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var logic  scl_oe_o,
  output var logic  sda_oe_o
);
  // ************************************************************
  // Bus master cycles
  // ************************************************************
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold
  // The device may keep the clock low while it saves, so wait for the line.
  task automatic rise();
    int i;
    scl_oe_o <= 1'b0;
    hold(1);
    for (i = 0; i < 3000 && scl_i !== 1'b1; i++) @(posedge clk_i);
    hold(H);
  endtask : rise
  task automatic bit_io(input logic b, output logic s);
    hold(2);
    sda_oe_o <= !b;
    hold(H);
    rise();
    s = sda_i;
    scl_oe_o <= 1'b1;
  endtask : bit_io
  task automatic start();
    hold(2);
    sda_oe_o <= 1'b0;
    hold(H);
    rise();
    sda_oe_o <= 1'b1;
    hold(H);
    scl_oe_o <= 1'b1;
  endtask : start
  task automatic stop();
    hold(2);
    sda_oe_o <= 1'b1;
    hold(H);
    rise();
    sda_oe_o <= 1'b0;
    hold(H);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask : rbyte
endmodule : blcfg_i2c_master
`default_nettype wire

//--- sim/blcfg_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module blcfg_regs_tb;
  // ************************************************************
  // Bench
  // ************************************************************
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic       m_scl_oe, m_sda_oe, d_scl_oe, d_sda_oe, ocen, rdsel, trig, ack;
  logic [1:0] slew;
  logic [7:0] q0, q1;
  wire logic  scl = !(m_scl_oe || d_scl_oe);
  wire logic  sda = !(m_sda_oe || d_sda_oe);
  int         fails = 0, n_compared = 0, cyc = 0, t0;
  blcfg_regs #(.SAVE_CYCLES(1000)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda), .scl_o(), .scl_oe_o(d_scl_oe), .sda_o(), .sda_oe_o(d_sda_oe),
    .slew_rate_sel_o(slew), .overcurrent_shutdown_en_o(ocen), .nv_read_select_o(rdsel),
    .nv_save_trigger_o(trig));
  blcfg_i2c_master m (.clk_i(ref_clk_i), .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe),
    .sda_oe_o(m_sda_oe));
  always #2.5 ref_clk_i = !ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n);
    m.start();
    m.wbyte(8'h58, ack);
    chk({7'h00, ack}, 8'h00);
    m.wbyte(a, ack);
    chk({7'h00, ack}, 8'h00);
    for (int i = 0; i < n; i++) begin
      m.wbyte(i == 0 ? d0 : d1, ack);
      chk({7'h00, ack}, 8'h00);
    end
    m.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n);
    m.start();
    m.wbyte(8'h58, ack);
    m.wbyte(a, ack);
    m.start();
    m.wbyte(8'h59, ack);
    chk({7'h00, ack}, 8'h00);
    m.rbyte(n == 1, q0);
    if (n == 2) m.rbyte(1'b1, q1);
    m.stop();
  endtask : rd
  task automatic t_reset();
    chk({6'h00, slew}, 8'h00);
    chk({7'h00, ocen}, 8'h00);
    chk({6'h00, trig, rdsel}, 8'h00);
    rd(8'hA4, 2);
    chk(q0, 8'h00);
    chk(q1, 8'h00);
    rd(8'hFF, 1);
    chk(q0, 8'h00);
  endtask : t_reset
  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      wr(8'hA4, 8'hFC | 8'(c), 8'h00, 1);
      chk({6'h00, slew}, 8'(c));
      rd(8'hA4, 1);
      chk(q0, 8'(c));
    end
  endtask : t_codes
  task automatic t_burst();
    wr(8'hA4, 8'hFE, 8'hFF, 2);
    chk({5'h00, slew, ocen}, 8'h05);
    rd(8'hA4, 2);
    chk(q0, 8'h02);
    chk(q1, 8'h01);
  endtask : t_burst
  task automatic t_unmapped();
    wr(8'hA0, 8'h55, 8'h00, 1);
    rd(8'hA0, 1);
    chk(q0, 8'h00);
    wr(8'hFF, 8'h7E, 8'h00, 1);
    rd(8'hFF, 1);
    chk(q0, 8'h00);
    m.start();
    m.wbyte(8'h5A, ack);
    chk({7'h00, ack}, 8'h01);
    m.stop();
  endtask : t_unmapped
  task automatic t_save();
    // The enable and dimming pins lie outside this block, so they are taken as already set.
    wr(8'hFF, 8'h80, 8'h00, 1);
    chk({7'h00, trig}, 8'h01);
    m.start();
    t0 = cyc;
    m.wbyte(8'h58, ack);
    chk({7'h00, (cyc - t0) > 500}, 8'h01);
    chk({6'h00, trig, ack}, 8'h00);
    m.wbyte(8'hA5, ack);
    m.wbyte(8'h00, ack);
    m.stop();
    chk({7'h00, ocen}, 8'h00);
    wr(8'hFF, 8'h01, 8'h00, 1);
    chk({7'h00, rdsel}, 8'h01);
    rd(8'hA4, 2);
    chk(q0, 8'h02);
    chk(q1, 8'h01);
    rd(8'hFF, 1);
    chk(q0, 8'h01);
    wr(8'hFF, 8'h00, 8'h00, 1);
    rd(8'hA5, 1);
    chk(q0, 8'h00);
  endtask : t_save
  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // Reset stands for two edges; the idle gap after it lets the pin synchronisers settle high.
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_codes();
    t_burst();
    t_unmapped();
    t_save();
    stop_test();
  end
endmodule : blcfg_regs_tb
`default_nettype wire
